//--- design/timer_pin_io_control_decode.sv
`timescale 1ns/1ns
module timer_pin_io_control_decode (
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer counters and events from the rest of the timer
    input wire logic [15:0] ch0_counter,
    input wire logic [15:0] ch1_counter,
    input wire logic ch1_count_tick,
    input wire logic ch0_reg_c_event,
    // Pin of channel 0 register D
    input wire logic ch0_pin_d_in,
    output logic ch0_pin_d_out,
    output logic ch0_pin_d_oe,
    // Pin of channel 1 register B
    input wire logic ch1_pin_b_in,
    output logic ch1_pin_b_out,
    output logic ch1_pin_b_oe,
    // Event pulses
    output logic ch0_reg_d_match,
    output logic ch0_reg_d_capture,
    output logic ch1_reg_b_match,
    output logic ch1_reg_b_capture
);

    // Software-visible registers
    logic [7:0] ch0_low_io_control;
    logic [7:0] ch1_io_control;
    logic [7:0] ch0_mode_register;
    logic [15:0] gen_reg [2];

    // Per-channel pin and event state
    logic [1:0] pin_level;
    logic [1:0] pin_drive;
    logic [1:0] pin_stable;
    logic [1:0] match_pulse;
    logic [1:0] capture_pulse;

    // Per-channel views of shared inputs
    logic [3:0] field [2];
    logic [15:0] counter [2];
    logic [1:0] special_src;
    logic [1:0] field_written;
    logic [1:0] pin_raw;
    logic [1:0] disabled;

    // Bus decode and status word
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] status_word;

    // Bus decode: one wait state, write lands when pready is seen
    assign access = psel && penable && pready;
    assign wr = access && pwrite;
    // Six word addresses answer; any other raises pslverr
    assign mapped = (paddr == timer_pin_io_pkg::ch0_low_io_control_addr)
        || (paddr == timer_pin_io_pkg::ch1_io_control_addr)
        || (paddr == timer_pin_io_pkg::ch0_mode_register_addr)
        || (paddr == timer_pin_io_pkg::ch0_general_reg_d_addr)
        || (paddr == timer_pin_io_pkg::ch1_general_reg_b_addr)
        || (paddr == timer_pin_io_pkg::pin_status_addr);

    // Per-channel views of fields, counters and sources
    // Only bits 7..4 of each byte steer the pins here
    assign field[0] = ch0_low_io_control[timer_pin_io_pkg::field_hi_lsb +: 4];
    assign field[1] = ch1_io_control[timer_pin_io_pkg::field_hi_lsb +: 4];
    assign counter[0] = ch0_counter;
    assign counter[1] = ch1_counter;
    assign special_src[0] = ch1_count_tick;
    assign special_src[1] = ch0_reg_c_event;
    assign pin_raw[0] = ch0_pin_d_in;
    assign pin_raw[1] = ch1_pin_b_in;
    // Field writes set the starting state of the pin
    assign field_written[0] = wr && (paddr == timer_pin_io_pkg::ch0_low_io_control_addr);
    assign field_written[1] = wr && (paddr == timer_pin_io_pkg::ch1_io_control_addr);
    // Register D acting as buffer has no events of its own
    assign disabled[0] = ch0_mode_register[timer_pin_io_pkg::reg_b_buffer_mode_bit];
    // Channel 1 register B has no buffer role here
    assign disabled[1] = 1'b0;

    // Pin status word: levels, synchronised inputs, enables
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[timer_pin_io_pkg::stat_pin_out_lsb +: 2] = pin_level;
        status_word[timer_pin_io_pkg::stat_pin_in_lsb +: 2] = pin_stable;
        status_word[timer_pin_io_pkg::stat_pin_oe_lsb +: 2] = pin_drive;
    end

    // Bus handshake and read data
    // Every access takes one wait state; ready never stays high
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            // Read data stands only in the ready cycle
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    timer_pin_io_pkg::ch0_low_io_control_addr: begin
                        prdata <= {24'h00_0000, ch0_low_io_control};
                    end
                    timer_pin_io_pkg::ch1_io_control_addr: begin
                        prdata <= {24'h00_0000, ch1_io_control};
                    end
                    timer_pin_io_pkg::ch0_mode_register_addr: begin
                        prdata <= {24'h00_0000, ch0_mode_register};
                    end
                    timer_pin_io_pkg::ch0_general_reg_d_addr: begin
                        prdata <= {16'h0000, gen_reg[0]};
                    end
                    timer_pin_io_pkg::ch1_general_reg_b_addr: begin
                        prdata <= {16'h0000, gen_reg[1]};
                    end
                    timer_pin_io_pkg::pin_status_addr: begin
                        prdata <= status_word;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Control registers, zero after reset
    // Unmapped writes fall through with no effect
    always_ff @(posedge clk) begin
        if (rst) begin
            ch0_low_io_control <= timer_pin_io_pkg::ctl_reset;
            ch1_io_control <= timer_pin_io_pkg::ctl_reset;
            ch0_mode_register <= timer_pin_io_pkg::mode_reset;
        end else if (wr) begin
            if (paddr == timer_pin_io_pkg::ch0_low_io_control_addr) begin
                ch0_low_io_control <= pwdata[7:0];
            end
            if (paddr == timer_pin_io_pkg::ch1_io_control_addr) begin
                ch1_io_control <= pwdata[7:0];
            end
            if (paddr == timer_pin_io_pkg::ch0_mode_register_addr) begin
                ch0_mode_register <= pwdata[7:0];
            end
        end
    end

    // One pin, one general register per channel
    // Channel 0 is register D, channel 1 register B
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        // Synchroniser stages and edge flags
        logic sync1;
        logic sync2;
        logic sync3;
        logic in_edge;
        logic rise;
        logic fall;

        // Event decode
        logic is_capture;
        logic cap_hit;
        logic cmp_hit;

        // Bus hit and written field
        logic gen_written;
        logic [3:0] wfield;

        assign wfield = pwdata[timer_pin_io_pkg::field_hi_lsb +: 4];
        assign gen_written = wr && (paddr == ((ch == 0)
            ? timer_pin_io_pkg::ch0_general_reg_d_addr
            : timer_pin_io_pkg::ch1_general_reg_b_addr));
        assign is_capture = field[ch][timer_pin_io_pkg::fld_capture];

        // Pin input: three flops, change counts once the last two agree
        // Reset level 0 matches the driven-low pin: no false edge
        always_ff @(posedge clk) begin
            if (rst) begin
                sync1 <= 1'b0;
                sync2 <= 1'b0;
                sync3 <= 1'b0;
                pin_stable[ch] <= 1'b0;
            end else begin
                sync1 <= pin_raw[ch];
                sync2 <= sync1;
                sync3 <= sync2;
                if (sync2 == sync3) begin
                    pin_stable[ch] <= sync3;
                end
            end
        end
        // Edge flag lasts one cycle, until pin_stable catches up
        assign in_edge = (sync2 == sync3) && (sync3 != pin_stable[ch]);
        assign rise = in_edge && sync3;
        assign fall = in_edge && !sync3;

        // Event decode from the control field
        // Special source outranks the edge bits
        always_comb begin
            cap_hit = 1'b0;
            if (field[ch][timer_pin_io_pkg::fld_special]) begin
                cap_hit = special_src[ch];
            end else if (field[ch][timer_pin_io_pkg::fld_both]) begin
                cap_hit = rise || fall;
            end else if (field[ch][timer_pin_io_pkg::fld_falling]) begin
                cap_hit = fall;
            end else begin
                cap_hit = rise;
            end
            // Gate by mode and buffer state
            cap_hit = cap_hit && is_capture && !disabled[ch];
            // Compare path, closed in capture and buffer mode
            cmp_hit = !is_capture && !disabled[ch] && (counter[ch] == gen_reg[ch]);
        end

        // General register: capture wins over a software write
        // A write that meets a capture is lost; software re-checks
        always_ff @(posedge clk) begin
            if (rst) begin
                gen_reg[ch] <= timer_pin_io_pkg::gen_reset;
            end else if (cap_hit) begin
                gen_reg[ch] <= counter[ch];
            end else if (gen_written) begin
                gen_reg[ch] <= pwdata[15:0];
            end
        end

        // Event pulses
        // Registered: a pulse trails the equal cycle by one edge
        always_ff @(posedge clk) begin
            if (rst) begin
                match_pulse[ch] <= 1'b0;
                capture_pulse[ch] <= 1'b0;
            end else begin
                match_pulse[ch] <= cmp_hit;
                capture_pulse[ch] <= cap_hit;
            end
        end

        // Pin drive: level 0 with oe high after reset, initial level on write, action on match
        // A field write beats a match in the same cycle
        always_ff @(posedge clk) begin
            if (rst) begin
                pin_level[ch] <= 1'b0;
                pin_drive[ch] <= 1'b1;
            end else if (field_written[ch]) begin
                pin_drive[ch] <= !wfield[timer_pin_io_pkg::fld_capture];
                if (!wfield[timer_pin_io_pkg::fld_capture]
                    && (wfield[1:0] != timer_pin_io_pkg::act_retain)) begin
                    pin_level[ch] <= wfield[timer_pin_io_pkg::fld_level];
                end
            end else if (cmp_hit) begin
                case (field[ch][1:0])
                    timer_pin_io_pkg::act_low: begin
                        pin_level[ch] <= 1'b0;
                    end
                    timer_pin_io_pkg::act_high: begin
                        pin_level[ch] <= 1'b1;
                    end
                    timer_pin_io_pkg::act_toggle: begin
                        pin_level[ch] <= !pin_level[ch];
                    end
                    default: begin
                        pin_level[ch] <= pin_level[ch];
                    end
                endcase
            end
        end
    end

    // Outputs straight from flops
    // Oe falls in capture mode so the far side owns the pin
    assign ch0_pin_d_out = pin_level[0];
    assign ch0_pin_d_oe = pin_drive[0];
    assign ch1_pin_b_out = pin_level[1];
    assign ch1_pin_b_oe = pin_drive[1];
    assign ch0_reg_d_match = match_pulse[0];
    assign ch0_reg_d_capture = capture_pulse[0];
    assign ch1_reg_b_match = match_pulse[1];
    assign ch1_reg_b_capture = capture_pulse[1];

endmodule : timer_pin_io_control_decode

//--- shared/timer_pin_io_pkg.sv
package timer_pin_io_pkg;
    // Register byte offsets
    localparam logic [7:0] ch0_low_io_control_addr = 8'h00;
    localparam logic [7:0] ch1_io_control_addr = 8'h04;
    localparam logic [7:0] ch0_mode_register_addr = 8'h08;
    localparam logic [7:0] ch0_general_reg_d_addr = 8'h0c;
    localparam logic [7:0] ch1_general_reg_b_addr = 8'h10;
    localparam logic [7:0] pin_status_addr = 8'h14;
    // Widths
    localparam int addr_width = 8;
    localparam int gen_width = 16;
    localparam int ctl_width = 8;
    // Control field positions
    localparam int field_hi_lsb = 4;
    localparam int field_lo_lsb = 0;
    localparam int field_width = 4;
    localparam int fld_capture = 3;
    localparam int fld_special = 2;
    localparam int fld_level = 2;
    localparam int fld_both = 1;
    localparam int fld_falling = 0;
    // Mode register buffer bit
    localparam int reg_b_buffer_mode_bit = 5;
    // Reset values
    localparam logic [7:0] ctl_reset = 8'h00;
    localparam logic [15:0] gen_reset = 16'hffff;
    localparam logic [7:0] mode_reset = 8'h00;
    // Compare actions in the low pair
    localparam logic [1:0] act_retain = 2'h0;
    localparam logic [1:0] act_low = 2'h1;
    localparam logic [1:0] act_high = 2'h2;
    localparam logic [1:0] act_toggle = 2'h3;
    // Pin status bit positions
    localparam int stat_pin_out_lsb = 0;
    localparam int stat_pin_in_lsb = 2;
    localparam int stat_pin_oe_lsb = 4;
endpackage : timer_pin_io_pkg

//--- verification/pin_partner.sv
`timescale 1ns/1ns
module pin_partner (
    input wire logic lvl,
    input wire logic out,
    input wire logic oe,
    output logic pin
);
    // Device level wins while it drives, else the far side
    assign pin = oe ? out : lvl;
endmodule : pin_partner

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] c0 = 16'h0, c1 = 16'h0;
    logic tick = 1'b0, cev = 1'b0, lvd = 1'b0, lvb = 1'b0, pready, pslverr, er;
    logic dout, doe, din, bout, boe, bin, dm, dc, bmt, bc;
    int err_total = 0, check_count = 0, ndm = 0, ndc = 0, nbc = 0, nbm = 0, base;
    always #50 clk = ~clk;
    // Event pulse counters
    always @(posedge clk) begin
        ndm += dm;
        ndc += dc;
        nbc += bc;
        nbm += bmt;
    end
    timer_pin_io_control_decode dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch0_counter(c0), .ch1_counter(c1), .ch1_count_tick(tick),
        .ch0_reg_c_event(cev), .ch0_pin_d_in(din), .ch0_pin_d_out(dout), .ch0_pin_d_oe(doe),
        .ch1_pin_b_in(bin), .ch1_pin_b_out(bout), .ch1_pin_b_oe(boe), .ch0_reg_d_match(dm),
        .ch0_reg_d_capture(dc), .ch1_reg_b_match(bmt), .ch1_reg_b_capture(bc));
    pin_partner pd_u (.lvl(lvd), .out(dout), .oe(doe), .pin(din));
    pin_partner pb_u (.lvl(lvb), .out(bout), .oe(boe), .pin(bin));
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, seen, exp);
        end
    endtask : check
    // One APB transfer, bounded wait for ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            test_done;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        xfer(1'b0, a, 32'h0);
        check(rd, exp, m);
    endtask : rchk
    task automatic t_reset;
        rchk(8'h00, 32'h0, "field d c");
        rchk(8'h04, 32'h0, "field b");
        rchk(8'h08, 32'h0, "mode");
        xfer(1'b0, 8'h14, 32'h0);
        check({30'h0, rd[1:0]}, 32'h0, "pin out");
        check({30'h0, rd[5:4]}, 32'h3, "pin drive");
        rchk(8'h18, 32'h0, "unmapped");
        check({31'h0, er}, 32'h1, "slverr");
        xfer(1'b1, 8'h00, 32'ha5);
        rchk(8'h00, 32'ha5, "field position");
    endtask : t_reset
    task automatic t_compare;
        logic init;
        logic exp_lvl;
        xfer(1'b1, 8'h0c, 32'h0100);
        for (int i = 1; i < 8; i++) begin
            if (i == 4) continue;
            xfer(1'b1, 8'h00, 32'(i << 4));
            @(posedge clk);
            init = dout;
            check({31'h0, dout}, {31'h0, i[2]}, "initial");
            base = ndm;
            c0 <= 16'h0100;
            @(posedge clk);
            c0 <= 16'h0000;
            repeat (3) @(posedge clk);
            check(ndm - base, 32'h1, "match count");
            exp_lvl = (i[1:0] == 2'h3) ? !init : i[1];
            check({31'h0, dout}, {31'h0, exp_lvl}, "act");
        end
        for (int i = 4; i >= 0; i -= 4) begin
            init = dout;
            xfer(1'b1, 8'h00, 32'(i << 4));
            @(posedge clk);
            check({31'h0, dout}, {31'h0, init}, "retain");
        end
    endtask : t_compare
    task automatic t_capture;
        for (int i = 8; i < 12; i++) begin
            xfer(1'b1, 8'h04, 32'(i << 4));
            c1 <= 16'h1230 + 16'(i);
            base = nbc;
            lvb <= 1'b1;
            repeat (8) @(posedge clk);
            check(nbc - base, i == 9 ? 0 : 1, "rise");
            base = nbc;
            lvb <= 1'b0;
            repeat (8) @(posedge clk);
            check(nbc - base, i == 8 ? 0 : 1, "fall");
        end
        check({31'h0, boe}, 32'h0, "b released");
        rchk(8'h10, 32'h123b, "captured value");
        xfer(1'b1, 8'h04, 32'hc0);
        base = nbc;
        cev <= 1'b1;
        @(posedge clk);
        cev <= 1'b0;
        repeat (4) @(posedge clk);
        check(nbc - base, 32'h1, "event capture");
    endtask : t_capture
    task automatic t_source;
        for (int m = 0; m < 2; m++) begin
            xfer(1'b1, 8'h08, 32'(m << 5));
            xfer(1'b1, 8'h00, 32'hc0);
            base = ndc;
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (4) @(posedge clk);
            check(ndc - base, 32'(1 - m), "tick capture");
        end
        xfer(1'b1, 8'h00, 32'h30);
        base = ndm;
        c0 <= 16'h0100;
        @(posedge clk);
        c0 <= 16'h0000;
        repeat (4) @(posedge clk);
        check(ndm - base, 32'h0, "buffer match");
    endtask : t_source
    task automatic t_chan1;
        xfer(1'b1, 8'h10, 32'h0200);
        xfer(1'b1, 8'h04, 32'h20);
        @(posedge clk);
        check({30'h0, boe, bout}, 32'h2, "b initial");
        base = nbm;
        c1 <= 16'h0200;
        @(posedge clk);
        c1 <= 16'h0000;
        repeat (3) @(posedge clk);
        check(nbm - base, 32'h1, "b match count");
        check({31'h0, bout}, 32'h1, "b high");
        rchk(8'h14, 32'h3a, "status");
    endtask : t_chan1
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_compare;
        t_capture;
        t_source;
        t_chan1;
        test_done;
    end
endmodule : tb

//--- verification/timer_pin_io_props.sv
`timescale 1ns/1ns
module timer_pin_io_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic ch1_count_tick,
    input wire logic ch0_reg_c_event,
    input wire logic ch1_pin_b_in,
    input wire logic ch0_pin_d_out,
    input wire logic ch0_reg_d_match,
    input wire logic ch0_reg_d_capture,
    input wire logic ch1_reg_b_capture
);
    logic [3:0] fd;
    logic [3:0] fb;
    logic bm;
    wire wr = psel && penable && pready && pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Mirror of the fields written over the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            fd <= 4'h0;
            fb <= 4'h0;
            bm <= 1'b0;
        end else if (wr) begin
            if (paddr == 8'h00) fd <= pwdata[7:4];
            if (paddr == 8'h04) fb <= pwdata[7:4];
            if (paddr == 8'h08) bm <= pwdata[5];
        end
    end
    a_ready_one_wait: assert property ((psel && !penable) ##1 (psel && penable)
        |-> !pready ##1 pready) else $error("ready not after one wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_reset_pin_low: assert property (disable iff (1'b0) rst |=> !ch0_pin_d_out)
        else $error("pin not low in reset");
    a_match_low: assert property (ch0_reg_d_match && fd == 4'h1 && $stable(fd)
        |-> !ch0_pin_d_out) else $error("match did not drive low");
    a_match_high: assert property (ch0_reg_d_match && fd == 4'h2 && $stable(fd)
        |-> ch0_pin_d_out) else $error("match did not drive high");
    a_match_toggle: assert property (ch0_reg_d_match && fd == 4'h3 && $stable(fd)
        |-> ch0_pin_d_out != $past(ch0_pin_d_out)) else $error("match did not toggle");
    a_rise_capture: assert property (fb == 4'h8 && $stable(fb) && $rose(ch1_pin_b_in)
        |-> ##[2:6] ch1_reg_b_capture) else $error("no rising capture");
    a_both_capture: assert property (fb == 4'hb && $stable(fb) && $fell(ch1_pin_b_in)
        |-> ##[2:6] ch1_reg_b_capture) else $error("no falling capture");
    a_tick_capture: assert property (fd == 4'hc && !bm && $stable(fd) && ch1_count_tick
        |-> ##[1:2] ch0_reg_d_capture) else $error("no tick capture");
    a_event_capture: assert property (fb == 4'hc && $stable(fb) && ch0_reg_c_event
        |-> ##[1:2] ch1_reg_b_capture) else $error("no event capture");
    a_buffer_quiet: assert property (bm && $past(bm)
        |-> !ch0_reg_d_match && !ch0_reg_d_capture) else $error("event in buffer mode");
endmodule : timer_pin_io_props
bind timer_pin_io_control_decode timer_pin_io_props chk_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .ch1_count_tick(ch1_count_tick), .ch0_reg_c_event(ch0_reg_c_event),
    .ch1_pin_b_in(ch1_pin_b_in), .ch0_pin_d_out(ch0_pin_d_out),
    .ch0_reg_d_match(ch0_reg_d_match), .ch0_reg_d_capture(ch0_reg_d_capture),
    .ch1_reg_b_capture(ch1_reg_b_capture));
